// [bench/mie_core_monitor.sv]
// port checker of the instruction execute core
// assumes an instruction cycle of 8 clocks
`timescale 1ns/100ps
module mie_core_monitor #(parameter int DM_AW = 9) (
   input wire logic             CLOCK_I,
   input wire logic             RESET_I,
   input wire logic             REG_RD_I,
   input wire logic [7:0]       REG_RDATA_O,
   input wire logic             PM_RD_O,
   input wire logic [DM_AW-1:0] DM_ADDR_O,
   input wire logic             DM_RD_O,
   input wire logic             DM_WE_O,
   input wire logic             HALT_O,
   input wire logic             INSTR_START_O
);
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (RESET_I);
   sequence s_fetch; PM_RD_O ##1 !PM_RD_O; endsequence
   sequence s_gap; !INSTR_START_O [*7]; endsequence
   AST_FETCH: assert property (INSTR_START_O |=> s_fetch) else $error("no fetch");
   AST_GAP: assert property (INSTR_START_O |=> s_gap) else $error("short cycle");
   AST_START_QUIET: assert property (INSTR_START_O |-> !DM_RD_O && !DM_WE_O) else $error("busy");
   AST_WE_PULSE: assert property (DM_WE_O |=> !DM_WE_O) else $error("long write");
   AST_PCL_NOWR: assert property (DM_WE_O |-> DM_ADDR_O != 'h6) else $error("pcl write");
   AST_HALT_QUIET: assert property (HALT_O |-> !PM_RD_O && !DM_WE_O) else $error("run in halt");
   AST_PM_ALONE: assert property (PM_RD_O |-> !DM_RD_O && !DM_WE_O) else $error("overlap");
   AST_RD_HOLD: assert property (!$past(REG_RD_I) |-> $stable(REG_RDATA_O)) else $error("rdata moved");
endmodule
bind mie_core mie_core_monitor #(.DM_AW(DM_AW)) mon_u (.CLOCK_I, .RESET_I, .REG_RD_I, .REG_RDATA_O,
   .PM_RD_O, .DM_ADDR_O, .DM_RD_O, .DM_WE_O, .HALT_O, .INSTR_START_O);

// [bench/mie_mem_model.sv]
// program and data memory on the far side of the core
// assumes single-cycle strobes, data one clock later
`timescale 1ns/100ps
module mie_mem_model (
   input  wire logic        clk_i,
   input  wire logic [12:0] pm_addr_i,
   input  wire logic        pm_rd_i,
   output logic      [23:0] pm_data_o = 24'h0,
   input  wire logic [8:0]  dm_addr_i,
   input  wire logic        dm_rd_i,
   input  wire logic        dm_we_i,
   input  wire logic [7:0]  dm_wdata_i,
   output logic      [7:0]  dm_rdata_o = 8'h0
);
   logic [23:0] pm [0:8191];
   logic [7:0]  dm [0:511];
   // released lines toggle so a late sample never looks valid
   always @(posedge clk_i) begin
      pm_data_o <= pm_rd_i ? pm[pm_addr_i] : ~pm_data_o;
      dm_rdata_o <= dm_rd_i ? dm[dm_addr_i] : ~dm_rdata_o;
      if (dm_we_i) dm[dm_addr_i] <= dm_wdata_i;
   end
endmodule

// [bench/test_mcu_instruction_execute.sv]
// self-checking bench of the instruction execute core
// assumes the memory model answers fetches and data reads
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module test_mcu_instruction_execute;
   logic        CLOCK_I = 1'b0, RESET_I = 1'b1, REG_WR_I = 1'b0, REG_RD_I = 1'b0;
   logic [2:0]  REG_ADDR_I = 3'h0;
   logic [7:0]  REG_WDATA_I = 8'h00, REG_RDATA_O, DM_WDATA_O, DM_RDATA_I, rd;
   logic [12:0] PM_ADDR_O;
   logic [8:0]  DM_ADDR_O;
   logic [23:0] PM_DATA_I;
   logic        PM_RD_O, DM_RD_O, DM_WE_O, HALT_O, INSTR_START_O;
   int          n_mismatch = 0, cmp_count = 0, a, b, c, s, z, cy, ac, ov, lo, hi, tw;
   always #2 CLOCK_I = ~CLOCK_I;
   mie_core dut_u (.CLOCK_I, .RESET_I, .REG_ADDR_I, .REG_WDATA_I, .REG_WR_I, .REG_RD_I, .REG_RDATA_O,
      .PM_ADDR_O, .PM_RD_O, .PM_DATA_I, .DM_ADDR_O, .DM_RD_O, .DM_RDATA_I, .DM_WE_O, .DM_WDATA_O,
      .WAKE_I(1'b0), .HALT_O, .WDT_EXPIRE_O(), .INSTR_START_O);
   mie_mem_model mem_u (.clk_i(CLOCK_I), .pm_addr_i(PM_ADDR_O), .pm_rd_i(PM_RD_O), .pm_data_o(PM_DATA_I),
      .dm_addr_i(DM_ADDR_O), .dm_rd_i(DM_RD_O), .dm_we_i(DM_WE_O), .dm_wdata_i(DM_WDATA_O),
      .dm_rdata_o(DM_RDATA_I));
   function automatic logic [23:0] ins(mie_pkg::mie_op_t o, logic [7:0] m);
      return {o, 10'h000, m};
   endfunction
   task automatic rw(input logic wr, input logic [2:0] ad, input logic [7:0] wd);
      @(posedge CLOCK_I);
      REG_WR_I <= wr;
      REG_RD_I <= !wr;
      REG_ADDR_I <= ad;
      REG_WDATA_I <= wd;
      @(posedge CLOCK_I);
      REG_WR_I <= 1'b0;
      REG_RD_I <= 1'b0;
      #1 rd = REG_RDATA_O;
   endtask
   task automatic final_report;
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge CLOCK_I);
      n_mismatch++;
      final_report;
   end
   initial begin
      void'($urandom(32'h62a34923));
      mem_u.pm[0] = ins(mie_pkg::OP_ADDM, 8'h10);
      mem_u.pm[1] = ins(mie_pkg::OP_INVERT_TO_ACCUMULATOR, 8'h10);
      mem_u.pm[2] = ins(mie_pkg::OP_CLR_M, 8'h11);
      mem_u.pm[3] = ins(mie_pkg::OP_SZ, 8'h11);
      mem_u.pm[4] = ins(mie_pkg::OP_ADD_AX, 8'h01);
      mem_u.pm[5] = ins(mie_pkg::OP_DEC, 8'h12);
      mem_u.pm[6] = ins(mie_pkg::OP_ITABRDL, 8'h13) | (24'h1 << mie_pkg::EXT_POS);
      mem_u.pm[7] = ins(mie_pkg::OP_DAA, 8'h14);
      mem_u.pm[8] = ins(mie_pkg::OP_HALT, 8'h00);
      for (int r = 0; r < 8; r++) begin
         a = (r == 1) ? 255 : $urandom_range(255);
         b = (r == 1) ? 1 : $urandom_range(255);
         c = (r == 0) ? 1 : $urandom_range(255);
         @(posedge CLOCK_I) RESET_I <= 1'b1;
         mem_u.dm[16] = b[7:0];
         mem_u.dm[17] = 8'h5a;
         mem_u.dm[18] = c[7:0];
         tw = $urandom;
         mem_u.pm[13'h1f01] = 24'(tw);
         repeat (10) @(posedge CLOCK_I);
         RESET_I <= 1'b0;
         rw(1'b1, mie_pkg::RG_ACC, a[7:0]);
         rw(1'b1, mie_pkg::RG_CTRL, 8'h01);
         for (int k = 0; k < 300 && HALT_O !== 1'b1; k++) @(posedge CLOCK_I);
         s = (a + b) & 255;
         cy = (a + b) >> 8;
         ac = ((a & 15) + (b & 15)) >> 4;
         ov = (((a & 127) + (b & 127)) >> 7) ^ cy;
         z = ((c - 1) & 255) == 0;
         lo = ((~s & 15) > 9) || ac;
         hi = (((~s >> 4) & 15) > 9) || cy;
         `CHK(HALT_O, 1'b1)
         `CHK(mem_u.dm[16], 8'(s))
         `CHK(mem_u.dm[17], 8'h00)
         `CHK(mem_u.dm[18], 8'(c - 1))
         `CHK(mem_u.dm[19], 8'(tw))
         `CHK(mem_u.dm[20], 8'((~s & 255) + (lo ? 6 : 0) + (hi ? 96 : 0)))
         rw(1'b0, mie_pkg::RG_THIGH, 8'h00);
         `CHK(rd, 8'(tw >> 8))
         rw(1'b0, mie_pkg::RG_TPTR, 8'h00);
         `CHK(rd, 8'h01)
         rw(1'b0, mie_pkg::RG_ACC, 8'h00);
         `CHK(rd, 8'(~s))
         rw(1'b0, mie_pkg::RG_STATUS, 8'h00);
         `CHK(rd, {3'b010, 1'(ov ^ (s >> 7)), 1'(ov), 1'(z), 1'(ac), 1'(hi)})
         $display("round %0d done", r);
      end
      final_report;
   end
endmodule

// [design/mie_core.sv]
// instruction execute core: fetch, decode and execute of the byte core
// assumes memories answer one clock after their read strobe
//
// Behaviour
// - extended skip takes three cycles when skipping, two otherwise
// - extended instruction writing program counter low byte takes three cycles
// - table read loads word from chosen or last page, high to table byte
// - incrementing table reads advance the table pointer before reading
// - skips test byte zero, nonzero, bit, or incremented/decremented zero; no flags
// - nibble exchange swaps halves; accumulator form leaves memory, one cycle
// - clear byte writes zero and leaves flags alone
// - add with carry sums accumulator, byte and carry; five flags updated
// - add sums accumulator with byte or immediate; five flags updated
// - and with byte or immediate stores result, only zero flag changes
// - call pushes next address, loads target, two cycles
// - clear bit zeroes only the chosen bit, flags unchanged
// - watchdog clear resets counter, expiry flag and power-down flag
// - invert writes complemented byte in place, only zero flag
// - invert to accumulator keeps memory, only zero flag
// - decimal adjust adds six per nibble above nine or carried, to memory
// - decimal adjust touches only carry, set when the high nibble is above nine or carry was set
// - decrement subtracts one in place, only zero flag
// - decrement to accumulator keeps memory unchanged
// - power-down stops execution, keeps state, clears watchdog and prescaler
// - power-down entry sets power-down flag, clears expiry flag
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps

module mie_core #(
   parameter int PC_W     = 13,
   parameter int DM_AW    = 9,
   parameter int STK_D    = 8,
   parameter int CYC_CLKS = 8,
   parameter int WPRE_W   = 4,
   parameter int WCNT_W   = 8
) (
   input  wire logic                       CLOCK_I,
   input  wire logic                       RESET_I,
   input  wire logic [2:0]                 REG_ADDR_I,
   input  wire logic [7:0]                 REG_WDATA_I,
   input  wire logic                       REG_WR_I,
   input  wire logic                       REG_RD_I,
   output wire logic [7:0]                 REG_RDATA_O,
   output wire logic [PC_W-1:0]            PM_ADDR_O,
   output wire logic                       PM_RD_O,
   input  wire logic [mie_pkg::INSTR_W-1:0] PM_DATA_I,
   output wire logic [DM_AW-1:0]           DM_ADDR_O,
   output wire logic                       DM_RD_O,
   input  wire logic [7:0]                 DM_RDATA_I,
   output wire logic                       DM_WE_O,
   output wire logic [7:0]                 DM_WDATA_O,
   input  wire logic                       WAKE_I,
   output wire logic                       HALT_O,
   output wire logic                       WDT_EXPIRE_O,
   output wire logic                       INSTR_START_O
);

   ////////////////////////////////////////////////////////////////////////////
   // parameter checks

   localparam int SP_W  = $clog2(STK_D);
   localparam int DIV_W = $clog2(CYC_CLKS);
   localparam int WDT_W = WPRE_W + WCNT_W;

   if (PC_W < mie_pkg::SHORT_AW + 1 || PC_W > mie_pkg::ARG_W) begin : g_chk_pc
      $error("PC_W out of range");
   end
   if (DM_AW < mie_pkg::SHORT_AW || DM_AW > mie_pkg::ARG_W) begin : g_chk_dm
      $error("DM_AW out of range");
   end
   if (CYC_CLKS < 8 || (1 << DIV_W) != CYC_CLKS) begin : g_chk_cyc
      $error("CYC_CLKS must be a power of two of at least 8");
   end
   if (STK_D < 2 || (1 << SP_W) != STK_D) begin : g_chk_stk
      $error("STK_D must be a power of two of at least 2");
   end

   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CYC_CLKS - 1);
   localparam logic [PC_W-1:0]  PC_INC   = PC_W'(mie_pkg::INC_ONE);
   localparam logic [PC_W-1:0]  PC_SKIP  = PC_W'(mie_pkg::SKIP_STEP);
   localparam logic [DM_AW-1:0] PCL_DM   = DM_AW'(mie_pkg::PCL_ADDR);

   ////////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      mie_pkg::mie_state_t             st;
      logic [DIV_W-1:0]                div;
      logic [1:0]                      rem;
      logic                            halt_pend;
      logic [mie_pkg::INSTR_W-1:0]     ir;
      logic [PC_W-1:0]                 pc;
      logic [STK_D-1:0][PC_W-1:0]      stk;
      logic [SP_W-1:0]                 sp;
      logic [7:0]                      acc;
      logic                            c;
      logic                            ac;
      logic                            z;
      logic                            ov;
      logic                            sc;
      logic                            watchdog_expiry_flag;
      logic                            power_down_flag;
      logic [7:0]                      table_pointer;
      logic [7:0]                      table_page;
      logic [7:0]                      table_high_byte;
      logic                            run;
      logic                            wdt_en;
      logic [WDT_W-1:0]                wdt;
      logic                            wdt_pulse;
      logic [PC_W-1:0]                 pm_addr;
      logic                            pm_rd;
      logic [DM_AW-1:0]                dm_addr;
      logic                            dm_rd;
      logic                            dm_we;
      logic [7:0]                      dm_wdata;
      logic [7:0]                      rdata;
      logic                            wake_s1;
      logic                            wake_s2;
   } mie_reg_t;

   mie_reg_t q_r;
   mie_reg_t q_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // operand decode and datapath

   mie_pkg::mie_op_t        op;
   logic                    ext;
   logic [mie_pkg::BIT_W-1:0] bsel;
   logic [mie_pkg::ARG_W-1:0] arg;
   logic [DM_AW-1:0]        dec_addr;
   logic [7:0]              mval;
   logic [7:0]              opb;
   logic                    cin;
   logic [8:0]              sum9;
   logic [4:0]              lo5;
   logic [7:0]              lo8;
   logic                    ovf;
   logic [7:0]              incv;
   logic [7:0]              decv;
   logic [7:0]              mask;
   logic                    lo_adj;
   logic                    hi_adj;
   logic [7:0]              daav;
   logic [7:0]              tp_use;
   logic [PC_W-1:0]         tbl_addr;
   logic                    tick;

   assign op       = mie_pkg::mie_op_t'(q_r.ir[mie_pkg::OP_LSB +: mie_pkg::OP_W]);
   assign ext      = q_r.ir[mie_pkg::EXT_POS];
   assign bsel     = q_r.ir[mie_pkg::BIT_LSB +: mie_pkg::BIT_W];
   assign arg      = q_r.ir[mie_pkg::ARG_W-1:0];
   // short forms reach only the first sector
   assign dec_addr = PM_DATA_I[mie_pkg::EXT_POS] ? PM_DATA_I[DM_AW-1:0]
                                                 : DM_AW'(PM_DATA_I[mie_pkg::SHORT_AW-1:0]);
   // the program counter low byte sits in data space
   assign mval     = (q_r.dm_addr == PCL_DM) ? q_r.pc[7:0] : DM_RDATA_I;
   assign opb      = (op == mie_pkg::OP_ADD_AX || op == mie_pkg::OP_AND_AX) ? arg[7:0] : mval;
   assign cin      = (op == mie_pkg::OP_ADC_AM || op == mie_pkg::OP_ADD_CARRY_TO_MEMORY) ? q_r.c : 1'b0;
   assign sum9     = 9'(q_r.acc) + 9'(opb) + 9'(cin);
   assign lo5      = 5'(q_r.acc[3:0]) + 5'(opb[3:0]) + 5'(cin);
   assign lo8      = 8'(q_r.acc[6:0]) + 8'(opb[6:0]) + 8'(cin);
   assign ovf      = lo8[7] ^ sum9[8];
   assign incv     = mval + mie_pkg::BYTE_ONE;
   assign decv     = mval - mie_pkg::BYTE_ONE;
   assign mask     = mie_pkg::BYTE_ONE << bsel;
   assign lo_adj   = (q_r.acc[3:0] > mie_pkg::BCD_MAX) || q_r.ac;
   assign hi_adj   = (q_r.acc[7:4] > mie_pkg::BCD_MAX) || q_r.c;
   assign daav     = q_r.acc + {hi_adj ? mie_pkg::BCD_ADJ : 4'h0,
                                lo_adj ? mie_pkg::BCD_ADJ : 4'h0};
   assign tp_use   = (op == mie_pkg::OP_ITABRD || op == mie_pkg::OP_ITABRDL)
                     ? q_r.table_pointer + mie_pkg::BYTE_ONE : q_r.table_pointer;
   assign tbl_addr = (op == mie_pkg::OP_TABRDL || op == mie_pkg::OP_ITABRDL)
                     ? {{(PC_W-8){1'b1}}, tp_use}
                     : {q_r.table_page[PC_W-9:0], tp_use};
   assign tick     = (q_r.div == DIV_LAST);

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      logic [7:0] res;
      logic [7:0] stat;
      logic       wm;
      logic       wa;
      logic       arith;
      logic       zf;
      logic       skp;
      logic       extra;
      logic [PC_W-1:0] pcn;
      res   = mie_pkg::BYTE_ZERO;
      stat  = mie_pkg::BYTE_ZERO;
      wm    = 1'b0;
      wa    = 1'b0;
      arith = 1'b0;
      zf    = 1'b0;
      skp   = 1'b0;
      extra = 1'b0;
      pcn   = q_r.pc + PC_INC;
      q_nxt = q_r;

      q_nxt.wake_s1   = WAKE_I;
      q_nxt.wake_s2   = q_r.wake_s1;
      q_nxt.div       = q_r.div + DIV_W'(mie_pkg::INC_ONE);
      q_nxt.pm_rd     = 1'b0;
      q_nxt.dm_rd     = 1'b0;
      q_nxt.dm_we     = 1'b0;
      q_nxt.wdt_pulse = 1'b0;

      // register port
      stat[mie_pkg::ST_C]   = q_r.c;
      stat[mie_pkg::ST_AC]  = q_r.ac;
      stat[mie_pkg::ST_Z]   = q_r.z;
      stat[mie_pkg::ST_OV]  = q_r.ov;
      stat[mie_pkg::ST_SC]  = q_r.sc;
      stat[mie_pkg::ST_TO]  = q_r.watchdog_expiry_flag;
      stat[mie_pkg::ST_PDF] = q_r.power_down_flag;
      if (REG_RD_I) begin
         case (REG_ADDR_I)
            mie_pkg::RG_ACC:    q_nxt.rdata = q_r.acc;
            mie_pkg::RG_STATUS: q_nxt.rdata = stat;
            mie_pkg::RG_TPTR:   q_nxt.rdata = q_r.table_pointer;
            mie_pkg::RG_TPAGE:  q_nxt.rdata = q_r.table_page;
            mie_pkg::RG_THIGH:  q_nxt.rdata = q_r.table_high_byte;
            mie_pkg::RG_PCLO:   q_nxt.rdata = q_r.pc[7:0];
            mie_pkg::RG_PCHI:   q_nxt.rdata = 8'(q_r.pc[PC_W-1:8]);
            default: begin
               q_nxt.rdata                   = mie_pkg::BYTE_ZERO;
               q_nxt.rdata[mie_pkg::CTRL_RUN] = q_r.run;
               q_nxt.rdata[mie_pkg::CTRL_WDT] = q_r.wdt_en;
            end
         endcase
      end
      if (REG_WR_I) begin
         case (REG_ADDR_I)
            mie_pkg::RG_ACC:    q_nxt.acc = REG_WDATA_I;
            mie_pkg::RG_STATUS: begin
               q_nxt.c  = REG_WDATA_I[mie_pkg::ST_C];
               q_nxt.ac = REG_WDATA_I[mie_pkg::ST_AC];
               q_nxt.z  = REG_WDATA_I[mie_pkg::ST_Z];
               q_nxt.ov = REG_WDATA_I[mie_pkg::ST_OV];
               q_nxt.sc = REG_WDATA_I[mie_pkg::ST_SC];
            end
            mie_pkg::RG_TPTR:   q_nxt.table_pointer = REG_WDATA_I;
            mie_pkg::RG_TPAGE:  q_nxt.table_page    = REG_WDATA_I;
            mie_pkg::RG_CTRL: begin
               q_nxt.run    = REG_WDATA_I[mie_pkg::CTRL_RUN];
               q_nxt.wdt_en = REG_WDATA_I[mie_pkg::CTRL_WDT];
            end
            default: begin
            end
         endcase
      end

      // watchdog: prescaler in the low bits, counter above; frozen while halted
      if (tick && q_r.wdt_en && q_r.st != mie_pkg::S_HALT) begin
         q_nxt.wdt = q_r.wdt + WDT_W'(mie_pkg::INC_ONE);
         if (&q_r.wdt) begin
            q_nxt.watchdog_expiry_flag = 1'b1;
            q_nxt.wdt_pulse            = 1'b1;
         end
      end

      // sequencer, one instruction cycle is CYC_CLKS clocks
      case (q_r.st)
         mie_pkg::S_WAIT: begin
            if (tick) begin
               if (q_r.rem <= mie_pkg::CYC_ONE) begin
                  q_nxt.rem = mie_pkg::CYC_ONE;
                  if (q_r.halt_pend) begin
                     q_nxt.halt_pend = 1'b0;
                     q_nxt.st        = mie_pkg::S_HALT;
                  end else if (q_r.run) begin
                     q_nxt.st = mie_pkg::S_FETCH;
                  end
               end else begin
                  q_nxt.rem = q_r.rem - mie_pkg::CYC_ONE;
               end
            end
         end
         mie_pkg::S_FETCH: begin
            q_nxt.pm_addr = q_r.pc;
            q_nxt.pm_rd   = 1'b1;
            q_nxt.st      = mie_pkg::S_FWAIT;
         end
         mie_pkg::S_FWAIT: q_nxt.st = mie_pkg::S_DEC;
         mie_pkg::S_DEC: begin
            q_nxt.ir      = PM_DATA_I;
            q_nxt.dm_addr = dec_addr;
            q_nxt.dm_rd   = 1'b1;
            q_nxt.st      = mie_pkg::S_DWAIT;
         end
         mie_pkg::S_DWAIT: q_nxt.st = mie_pkg::S_EXEC;
         mie_pkg::S_EXEC: begin
            q_nxt.st = mie_pkg::S_WAIT;
            case (op)
               mie_pkg::OP_ADD_AM, mie_pkg::OP_ADD_AX: begin
                  res = sum9[7:0]; wa = 1'b1; arith = 1'b1;
               end
               mie_pkg::OP_ADDM: begin
                  res = sum9[7:0]; wm = 1'b1; arith = 1'b1;
               end
               mie_pkg::OP_ADC_AM: begin
                  res = sum9[7:0]; wa = 1'b1; arith = 1'b1;
               end
               mie_pkg::OP_ADD_CARRY_TO_MEMORY: begin
                  res = sum9[7:0]; wm = 1'b1; arith = 1'b1;
               end
               mie_pkg::OP_AND_AM, mie_pkg::OP_AND_AX: begin
                  res = q_r.acc & opb; wa = 1'b1; zf = 1'b1;
               end
               mie_pkg::OP_ANDM: begin
                  res = q_r.acc & opb; wm = 1'b1; zf = 1'b1;
               end
               mie_pkg::OP_CALL: begin
                  q_nxt.stk[q_r.sp] = pcn;
                  q_nxt.sp          = q_r.sp + SP_W'(mie_pkg::INC_ONE);
                  pcn               = arg[PC_W-1:0];
                  extra             = 1'b1;
               end
               mie_pkg::OP_CLR_M: begin
                  res = mie_pkg::BYTE_ZERO; wm = 1'b1;
               end
               mie_pkg::OP_SET_M: begin
                  res = mie_pkg::BYTE_ALL; wm = 1'b1;
               end
               mie_pkg::OP_CLR_BIT: begin
                  res = mval & ~mask; wm = 1'b1;
               end
               mie_pkg::OP_CLR_WDT: begin
                  q_nxt.wdt                  = '0;
                  // an expiry in this very cycle wins over the clear
                  q_nxt.watchdog_expiry_flag = q_nxt.wdt_pulse;
                  q_nxt.power_down_flag      = 1'b0;
               end
               mie_pkg::OP_CPL: begin
                  res = ~mval; wm = 1'b1; zf = 1'b1;
               end
               mie_pkg::OP_INVERT_TO_ACCUMULATOR: begin
                  res = ~mval; wa = 1'b1; zf = 1'b1;
               end
               mie_pkg::OP_DAA: begin
                  res     = daav; wm = 1'b1;
                  q_nxt.c = hi_adj;
               end
               mie_pkg::OP_DEC: begin
                  res = decv; wm = 1'b1; zf = 1'b1;
               end
               mie_pkg::OP_DECREMENT_TO_ACCUMULATOR: begin
                  res = decv; wa = 1'b1; zf = 1'b1;
               end
               mie_pkg::OP_HALT: begin
                  q_nxt.halt_pend            = 1'b1;
                  q_nxt.wdt                  = '0;
                  // an expiry in this very cycle wins over the clear
                  q_nxt.watchdog_expiry_flag = q_nxt.wdt_pulse;
                  q_nxt.power_down_flag      = 1'b1;
               end
               mie_pkg::OP_SZ:      skp = (mval == mie_pkg::BYTE_ZERO);
               mie_pkg::OP_SNZ:     skp = (mval != mie_pkg::BYTE_ZERO);
               mie_pkg::OP_SZ_BIT:  skp = ~mval[bsel];
               mie_pkg::OP_SNZ_BIT: skp = mval[bsel];
               mie_pkg::OP_SZA: begin
                  res = mval; wa = 1'b1; skp = (mval == mie_pkg::BYTE_ZERO);
               end
               mie_pkg::OP_SIZ: begin
                  res = incv; wm = 1'b1; skp = (incv == mie_pkg::BYTE_ZERO);
               end
               mie_pkg::OP_SDZ: begin
                  res = decv; wm = 1'b1; skp = (decv == mie_pkg::BYTE_ZERO);
               end
               mie_pkg::OP_SIZA: begin
                  res = incv; wa = 1'b1; skp = (incv == mie_pkg::BYTE_ZERO);
               end
               mie_pkg::OP_SDZA: begin
                  res = decv; wa = 1'b1; skp = (decv == mie_pkg::BYTE_ZERO);
               end
               mie_pkg::OP_TABRD, mie_pkg::OP_TABRDL,
               mie_pkg::OP_ITABRD, mie_pkg::OP_ITABRDL: begin
                  q_nxt.table_pointer = tp_use;
                  q_nxt.pm_addr       = tbl_addr;
                  q_nxt.pm_rd         = 1'b1;
                  q_nxt.st            = mie_pkg::S_TWAIT;
                  extra               = 1'b1;
               end
               mie_pkg::OP_SWAP: begin
                  res = {mval[3:0], mval[7:4]}; wm = 1'b1;
               end
               mie_pkg::OP_SWAPA: begin
                  res = {mval[3:0], mval[7:4]}; wa = 1'b1;
               end
               default: begin
               end
            endcase
            if (arith) begin
               q_nxt.c  = sum9[8];
               q_nxt.ac = lo5[4];
               q_nxt.ov = ovf;
               q_nxt.sc = ovf ^ res[7];
            end
            if (arith || zf) begin
               q_nxt.z = (res == mie_pkg::BYTE_ZERO);
            end
            if (wa) begin
               q_nxt.acc = res;
            end
            if (skp) begin
               pcn   = q_r.pc + PC_SKIP;
               extra = 1'b1;
            end
            if (wm && q_r.dm_addr == PCL_DM) begin
               pcn   = {q_r.pc[PC_W-1:8], res};
               extra = 1'b1;
            end else if (wm) begin
               q_nxt.dm_we    = 1'b1;
               q_nxt.dm_wdata = res;
            end
            q_nxt.pc  = pcn;
            // base cycle, one more for the long form, one for a branch or table
            q_nxt.rem = mie_pkg::CYC_ONE + {1'b0, ext} + {1'b0, extra};
         end
         mie_pkg::S_TWAIT: q_nxt.st = mie_pkg::S_TAB;
         mie_pkg::S_TAB: begin
            q_nxt.table_high_byte = PM_DATA_I[mie_pkg::TBL_HI_LSB +: mie_pkg::BYTE_W];
            q_nxt.dm_wdata        = PM_DATA_I[mie_pkg::BYTE_W-1:0];
            q_nxt.dm_we           = 1'b1;
            q_nxt.st              = mie_pkg::S_WAIT;
         end
         mie_pkg::S_HALT: begin
            if (q_r.wake_s2) begin
               q_nxt.st  = mie_pkg::S_WAIT;
               q_nxt.rem = mie_pkg::CYC_ONE;
            end
         end
         default: q_nxt.st = mie_pkg::S_WAIT;
      endcase
   end

   always_ff @(posedge CLOCK_I) begin
      if (RESET_I) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign REG_RDATA_O   = q_r.rdata;
   assign PM_ADDR_O     = q_r.pm_addr;
   assign PM_RD_O       = q_r.pm_rd;
   assign DM_ADDR_O     = q_r.dm_addr;
   assign DM_RD_O       = q_r.dm_rd;
   assign DM_WE_O       = q_r.dm_we;
   assign DM_WDATA_O    = q_r.dm_wdata;
   assign HALT_O        = (q_r.st == mie_pkg::S_HALT);
   assign WDT_EXPIRE_O  = q_r.wdt_pulse;
   assign INSTR_START_O = (q_r.st == mie_pkg::S_FETCH);

endmodule

// [design/mie_pkg.sv]
// constants, opcodes and state codes of the instruction execute core
// assumes a 24-bit program word and a byte-wide data memory
package mie_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // instruction word fields
   localparam int INSTR_W    = 24;
   localparam int OP_LSB     = 18;
   localparam int OP_W       = 6;
   localparam int EXT_POS    = 17;
   localparam int BIT_LSB    = 14;
   localparam int BIT_W      = 3;
   localparam int ARG_W      = 14;
   localparam int SHORT_AW   = 8;
   localparam int BYTE_W     = 8;
   localparam int NIB_W      = 4;
   localparam int TBL_HI_LSB = 8;
   localparam int INC_ONE    = 1;
   localparam int SKIP_STEP  = 2;

   localparam logic [7:0] PCL_ADDR  = 8'h06;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_ALL  = 8'hff;
   localparam logic [7:0] BYTE_ONE  = 8'h01;
   localparam logic [3:0] BCD_MAX   = 4'h9;
   localparam logic [3:0] BCD_ADJ   = 4'h6;
   localparam logic [1:0] CYC_ONE   = 2'h1;

   ////////////////////////////////////////////////////////////////////////////
   // register indexes and bit positions
   localparam logic [2:0] RG_ACC    = 3'h0;
   localparam logic [2:0] RG_STATUS = 3'h1;
   localparam logic [2:0] RG_TPTR   = 3'h2;
   localparam logic [2:0] RG_TPAGE  = 3'h3;
   localparam logic [2:0] RG_THIGH  = 3'h4;
   localparam logic [2:0] RG_PCLO   = 3'h5;
   localparam logic [2:0] RG_PCHI   = 3'h6;
   localparam logic [2:0] RG_CTRL   = 3'h7;

   localparam int ST_C   = 0;
   localparam int ST_AC  = 1;
   localparam int ST_Z   = 2;
   localparam int ST_OV  = 3;
   localparam int ST_SC  = 4;
   localparam int ST_TO  = 5;
   localparam int ST_PDF = 6;

   localparam int CTRL_RUN = 0;
   localparam int CTRL_WDT = 1;

   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic [OP_W-1:0] {
      OP_NOP, OP_ADD_AM, OP_ADD_AX, OP_ADDM, OP_ADC_AM, OP_ADD_CARRY_TO_MEMORY,
      OP_AND_AM, OP_AND_AX, OP_ANDM, OP_CALL, OP_CLR_M, OP_SET_M,
      OP_CLR_BIT, OP_CLR_WDT, OP_CPL, OP_INVERT_TO_ACCUMULATOR, OP_DAA, OP_DEC,
      OP_DECREMENT_TO_ACCUMULATOR, OP_HALT, OP_SZ, OP_SZA, OP_SNZ, OP_SZ_BIT,
      OP_SNZ_BIT, OP_SIZ, OP_SDZ, OP_SIZA, OP_SDZA, OP_TABRD,
      OP_TABRDL, OP_ITABRD, OP_ITABRDL, OP_SWAP, OP_SWAPA
   } mie_op_t;

   typedef enum logic [3:0] {
      S_WAIT, S_FETCH, S_FWAIT, S_DEC, S_DWAIT, S_EXEC, S_TWAIT, S_TAB, S_HALT
   } mie_state_t;

endpackage
